// file: rtl/time_base_defs.svh
`ifndef TIME_BASE_DEFS_SVH
`define TIME_BASE_DEFS_SVH
// width of both time bases and the shared bus words
`define TB_W 24
// microcycle phase count and the phase on which the bases update
`define MC_PHASE_W 2
`define MC_PHASE_T2 2'h1
// fixed pre-dividers ahead of the prescalers
`define FIRST_SYS_DIV 2
`define SECOND_SYS_DIV 8
`define DIV_CNT_W 3
// prescaler field widths (factor is field plus one)
`define FIRST_PSC_W 8
`define SECOND_PSC_W 6
// tick filter control bit positions
`define TFC_CLK_BIT 0
`define TFC_TWO_SAMPLE_BIT 1
// integrating filter thresholds and saturation
`define INT_MAX 2'h3
`define INT_RISE 2'h2
`define INT_FALL 2'h1
// pending count accumulator width
`define PEND_W 3
`endif

// file: rtl/time_base_pkg.sv
package time_base_pkg;
  // first base clock source
  typedef enum logic [1:0] {
    FIRST_SYS_DIV2 = 2'h0,
    FIRST_PERIPH = 2'h1,
    FIRST_EXT = 2'h2,
    FIRST_EXT_ALT = 2'h3
  } first_clock_select_t;
  // second base clock source
  typedef enum logic [2:0] {
    SECOND_GATED = 3'h0,
    SECOND_INT = 3'h1,
    SECOND_RISE = 3'h2,
    SECOND_FALL = 3'h3,
    SECOND_BOTH = 3'h4,
    SECOND_OFF = 3'h5,
    SECOND_OFF6 = 3'h6,
    SECOND_OFF7 = 3'h7
  } second_clock_select_t;
  // role of a base on the shared bus
  typedef enum logic [1:0] {
    ROLE_LOCAL,
    ROLE_CLIENT,
    ROLE_SERVER
  } shared_role_t;
endpackage

// file: rtl/tick_prescaler.sv
`timescale 1ns/1ps
// divides a stream of count pulses by (div_i + 1)
module tick_prescaler #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // pulse stream
  input wire logic pulse_i,
  input wire logic [W-1:0] div_i,
  output logic pulse_o
);
  logic [W-1:0] cnt_ff;

  // counter restarts on the output pulse; a smaller div_i takes effect at once
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
    end else if (pulse_i) begin
      if (cnt_ff >= div_i) begin
        cnt_ff <= '0;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  assign pulse_o = pulse_i && (cnt_ff >= div_i);
endmodule

// file: rtl/tick_filter.sv
`timescale 1ns/1ps
`include "time_base_defs.svh"
// synchroniser plus integrating or two-sample filter for the tick input
module tick_filter (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // raw input and sample strobes
  input wire logic tick_i,
  input wire logic sys_div2_i,
  input wire logic chan_filt_clk_i,
  input wire logic [1:0] tick_filter_control_i,
  // filtered level
  output logic level_o
);
  logic sync1_ff, sync2_ff, prev_ff, level_ff;
  logic [1:0] int_ff;
  logic sample;

  // two-flop synchroniser; only the second stage is used downstream
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= tick_i;
      sync2_ff <= sync1_ff;
    end
  end

  assign sample = tick_filter_control_i[`TFC_CLK_BIT] ? chan_filt_clk_i : sys_div2_i;

  // integrator with hysteresis: two agreeing samples flip the level, so a
  // pulse wider than four system clocks always passes at the fast rate
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_ff <= 2'h0;
      prev_ff <= 1'b0;
      level_ff <= 1'b0;
    end else if (sample) begin
      prev_ff <= sync2_ff;
      if (tick_filter_control_i[`TFC_TWO_SAMPLE_BIT]) begin
        if (prev_ff == sync2_ff) begin
          level_ff <= sync2_ff;
        end
      end else if (sync2_ff) begin
        if (!level_ff && int_ff == `INT_FALL) begin
          level_ff <= 1'b1;
          int_ff <= `INT_MAX;
        end else if (int_ff != `INT_MAX) begin
          int_ff <= int_ff + 2'h1;
        end
      end else begin
        if (level_ff && int_ff == `INT_RISE) begin
          level_ff <= 1'b0;
          int_ff <= 2'h0;
        end else if (int_ff != 2'h0) begin
          int_ff <= int_ff - 2'h1;
        end
      end
    end
  end

  assign level_o = level_ff;
endmodule

// file: rtl/dual_time_base_counters.sv
`timescale 1ns/1ps
`include "time_base_defs.svh"
module dual_time_base_counters
  import time_base_pkg::*;
#(
  parameter int NCH = 32,
  parameter int W = `TB_W
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // clock sources
  input wire logic tick_i,
  input wire logic periph_tick_i,
  input wire logic chan_filt_clk_i,
  input wire logic angle_tick_i,
  // configuration
  input wire time_base_pkg::first_clock_select_t first_clock_select_i,
  input wire logic [`FIRST_PSC_W-1:0] first_prescale_field_i,
  input wire time_base_pkg::second_clock_select_t second_clock_select_i,
  input wire logic [`SECOND_PSC_W-1:0] second_prescale_field_i,
  input wire logic [1:0] tick_filter_control_i,
  input wire logic angle_mode_bit_i,
  input wire logic shared_enable_first_i,
  input wire logic shared_role_first_i,
  input wire logic shared_enable_second_i,
  input wire logic shared_role_second_i,
  // microengine writes
  input wire logic eng_wr_first_i,
  input wire logic eng_wr_second_i,
  input wire logic [W-1:0] eng_wdata_i,
  // shared time bus
  input wire logic [W-1:0] shared_first_i,
  input wire logic [W-1:0] shared_second_i,
  output logic [W-1:0] shared_first_o,
  output logic shared_first_oe_o,
  output logic [W-1:0] shared_second_o,
  output logic shared_second_oe_o,
  // time base buses, also the engine and host read values
  output logic [W-1:0] time_base_one_o,
  output logic [W-1:0] time_base_two_o,
  output logic [1:0] mc_phase_o,
  output logic angle_active_o,
  // channel 0 input path
  input wire logic chan0_filtered_i,
  output logic chan0_level_o,
  // channel match and capture
  input wire logic [NCH-1:0] match_on_first_i,
  input wire logic [NCH*W-1:0] match1_val_i,
  input wire logic [NCH*W-1:0] match2_val_i,
  input wire logic [NCH-1:0] match1_clr_i,
  input wire logic [NCH-1:0] match2_clr_i,
  input wire logic [NCH-1:0] transition_i,
  input wire logic [NCH-1:0] cap1_en_i,
  input wire logic [NCH-1:0] cap2_en_i,
  output logic [NCH-1:0] match1_latch_o,
  output logic [NCH-1:0] match2_latch_o,
  output logic [NCH*W-1:0] capture1_o,
  output logic [NCH*W-1:0] capture2_o
);
  import time_base_pkg::*;

  logic [`MC_PHASE_W-1:0] phase_ff;
  logic [`DIV_CNT_W-1:0] div_ff;
  logic sys_div2, sys_div8, at_t2;
  logic tick_f, tick_prev_ff, tick_rise, tick_fall;
  logic first_src, first_cnt, second_src, second_cnt;
  logic [W-1:0] tb1_ff, tb2_ff;
  // counts gathered between commits; three bits cover the four cycles of a microcycle
  logic [`PEND_W-1:0] pend1_ff, pend2_ff;
  // engine writes parked until the next commit
  logic [W-1:0] wdata1_ff, wdata2_ff;
  logic wr1_hold_ff, wr2_hold_ff;
  logic second_step;
  shared_role_t role1, role2;
  logic angle_on;

  // microcycle phase counter; phase T2 is the commit point of both bases
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_ff <= '0;
    end else begin
      phase_ff <= phase_ff + 1'b1;
    end
  end

  // fixed system clock pre-divider for the over-two and over-eight strobes
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  assign at_t2 = (phase_ff == `MC_PHASE_T2);
  assign sys_div2 = (div_ff[0] == 1'b1);
  assign sys_div8 = (div_ff == 3'h7);
  assign mc_phase_o = phase_ff;

  // shared bus roles: enable off leaves the base local
  always_comb begin
    role1 = ROLE_LOCAL;
    role2 = ROLE_LOCAL;
    if (shared_enable_first_i) begin
      role1 = shared_role_first_i ? ROLE_SERVER : ROLE_CLIENT;
    end
    if (shared_enable_second_i) begin
      role2 = shared_role_second_i ? ROLE_SERVER : ROLE_CLIENT;
    end
  end

  // a client never runs the angle counter, so the angle bit is dropped there
  assign angle_on = angle_mode_bit_i && (role2 != ROLE_CLIENT);
  assign angle_active_o = angle_on;

  // shared tick filter
  tick_filter u_tick_filter (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .tick_i(tick_i),
    .sys_div2_i(sys_div2),
    .chan_filt_clk_i(chan_filt_clk_i),
    .tick_filter_control_i(tick_filter_control_i),
    .level_o(tick_f)
  );

  // channel 0 shares the tick filter in angle mode for identical timing
  assign chan0_level_o = angle_on ? tick_f : chan0_filtered_i;

  // edge detect on the filtered tick
  // the previous level resets low like the idle tick, so reset makes no false edge
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_prev_ff <= 1'b0;
    end else begin
      tick_prev_ff <= tick_f;
    end
  end

  assign tick_rise = tick_f && !tick_prev_ff;
  assign tick_fall = !tick_f && tick_prev_ff;

  // first base source select
  // both external codes take the rising edge; falling edges only feed the second base
  always_comb begin
    case (first_clock_select_i)
      FIRST_SYS_DIV2: first_src = sys_div2;
      FIRST_PERIPH: first_src = periph_tick_i;
      FIRST_EXT: first_src = tick_rise;
      FIRST_EXT_ALT: first_src = tick_rise;
      default: first_src = 1'b0;
    endcase
  end

  tick_prescaler #(
    .W(`FIRST_PSC_W)
  ) u_first_psc (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .pulse_i(first_src),
    .div_i(first_prescale_field_i),
    .pulse_o(first_cnt)
  );

  // second base source select; angle mode bypasses all of these
  always_comb begin
    case (second_clock_select_i)
      SECOND_GATED: second_src = sys_div8 && tick_f;
      SECOND_INT: second_src = sys_div8;
      SECOND_RISE: second_src = tick_rise;
      SECOND_FALL: second_src = tick_fall;
      SECOND_BOTH: second_src = tick_rise || tick_fall;
      default: second_src = 1'b0;
    endcase
  end

  // gated rate: over 8 times 1..64 gives over 8 to over 512 in steps of 8
  tick_prescaler #(
    .W(`SECOND_PSC_W)
  ) u_second_psc (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .pulse_i(second_src),
    .div_i(second_prescale_field_i),
    .pulse_o(second_cnt)
  );

  // angle ticks replace the prescaled edge source while angle mode is on
  assign second_step = angle_on ? angle_tick_i : second_cnt;

  // engine writes are held until phase T2 so neither base moves mid-microcycle;
  // the hold drops at every T2, so a write is never applied twice
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr1_hold_ff <= 1'b0;
      wr2_hold_ff <= 1'b0;
      wdata1_ff <= '0;
      wdata2_ff <= '0;
    end else begin
      if (at_t2 || role1 == ROLE_CLIENT) begin
        wr1_hold_ff <= 1'b0;
      end else if (eng_wr_first_i) begin
        wr1_hold_ff <= 1'b1;
        wdata1_ff <= eng_wdata_i;
      end
      if (at_t2 || role2 == ROLE_CLIENT) begin
        wr2_hold_ff <= 1'b0;
      end else if (eng_wr_second_i) begin
        wr2_hold_ff <= 1'b1;
        wdata2_ff <= eng_wdata_i;
      end
    end
  end

  // first base: counts are gathered and applied together on phase T2
  // a client ignores engine writes and simply follows the imported word
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tb1_ff <= '0;
      pend1_ff <= '0;
    end else if (role1 == ROLE_CLIENT) begin
      pend1_ff <= '0;
      if (at_t2) begin
        tb1_ff <= shared_first_i;
      end
    end else if (at_t2) begin
      if (eng_wr_first_i) begin
        tb1_ff <= eng_wdata_i;
      end else if (wr1_hold_ff) begin
        tb1_ff <= wdata1_ff;
      end else begin
        tb1_ff <= tb1_ff + W'(pend1_ff) + W'(first_cnt);
      end
      pend1_ff <= '0;
    end else begin
      pend1_ff <= pend1_ff + `PEND_W'(first_cnt);
    end
  end

  // second base: one update point per microcycle keeps the bus steady
  // writes and imports land only at the commit, so the bus moves on T2 alone
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tb2_ff <= '0;
      pend2_ff <= '0;
    end else if (role2 == ROLE_CLIENT) begin
      pend2_ff <= '0;
      if (at_t2) begin
        tb2_ff <= shared_second_i;
      end
    end else if (at_t2) begin
      if (eng_wr_second_i) begin
        tb2_ff <= eng_wdata_i;
      end else if (wr2_hold_ff) begin
        tb2_ff <= wdata2_ff;
      end else begin
        tb2_ff <= tb2_ff + W'(pend2_ff) + W'(second_step);
      end
      pend2_ff <= '0;
    end else begin
      pend2_ff <= pend2_ff + `PEND_W'(second_step);
    end
  end

  // the internal buses are the engine and host read values; width set by W
  assign time_base_one_o = tb1_ff;
  assign time_base_two_o = tb2_ff;

  // export the very value driven to the local channels
  // the drive enable follows the role only; the peer must not serve at the same time
  assign shared_first_oe_o = (role1 == ROLE_SERVER);
  assign shared_first_o = tb1_ff;
  assign shared_second_oe_o = (role2 == ROLE_SERVER);
  assign shared_second_o = tb2_ff;

  // per-channel match latches and captures on the first base
  // the compare is unsigned, so a match value already behind the base hits at once
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_chan
      logic m1_ff, m2_ff, hit1, hit2, cap_evt;
      logic [W-1:0] c1_ff, c2_ff;

      assign hit1 = match_on_first_i[ch] && (tb1_ff >= match1_val_i[ch*W +: W]);
      assign hit2 = match_on_first_i[ch] && (tb1_ff >= match2_val_i[ch*W +: W]);

      // a hit in the clearing cycle keeps the latch set
      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          m1_ff <= 1'b0;
          m2_ff <= 1'b0;
        end else begin
          m1_ff <= hit1 || (m1_ff && !match1_clr_i[ch]);
          m2_ff <= hit2 || (m2_ff && !match2_clr_i[ch]);
        end
      end

      // capture on a new match or an input transition, no service needed
      assign cap_evt = (hit1 && !m1_ff) || (hit2 && !m2_ff) || transition_i[ch];

      always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          c1_ff <= '0;
          c2_ff <= '0;
        end else if (cap_evt) begin
          if (cap1_en_i[ch]) begin
            c1_ff <= tb1_ff;
          end
          if (cap2_en_i[ch]) begin
            c2_ff <= tb1_ff;
          end
        end
      end

      assign match1_latch_o[ch] = m1_ff;
      assign match2_latch_o[ch] = m2_ff;
      assign capture1_o[ch*W +: W] = c1_ff;
      assign capture2_o[ch*W +: W] = c2_ff;
    end
  endgenerate
endmodule

// file: test/dual_time_base_counters_props.sv
`timescale 1ns/1ps
// watches base commit timing and the shared bus direction
module dual_time_base_counters_chk #(
  parameter int W = 24
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // configuration and writes
  input wire logic eng_wr_second_i,
  input wire logic angle_mode_bit_i,
  input wire logic shared_enable_first_i,
  input wire logic shared_role_first_i,
  input wire logic shared_enable_second_i,
  input wire logic shared_role_second_i,
  // shared bus
  input wire logic [W-1:0] shared_first_i,
  input wire logic [W-1:0] shared_second_i,
  input wire logic [W-1:0] shared_first_o,
  input wire logic [W-1:0] shared_second_o,
  input wire logic shared_first_oe_o,
  input wire logic shared_second_oe_o,
  // bases and channel 0 path
  input wire logic [W-1:0] time_base_one_o,
  input wire logic [W-1:0] time_base_two_o,
  input wire logic [1:0] mc_phase_o,
  input wire logic angle_active_o,
  input wire logic chan0_filtered_i,
  input wire logic chan0_level_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic cl1;
  logic cl2;
  // client means attached to the bus but not serving
  assign cl1 = shared_enable_first_i && !shared_role_first_i;
  assign cl2 = shared_enable_second_i && !shared_role_second_i;
  // the three phases that follow a commit
  sequence s_rest;
    mc_phase_o == 2'h2 ##1 mc_phase_o == 2'h3 ##1 mc_phase_o == 2'h0;
  endsequence
  a_phase_walk: assert property (mc_phase_o == 2'h1 |=> s_rest)
    else $error("phase walk broken");
  a_two_stable: assert property (!$stable(time_base_two_o) |->
    $past(mc_phase_o) == 2'h1)
    else $error("second base moved off commit");
  a_second_oe: assert property (shared_second_oe_o == (!cl2 && shared_enable_second_i))
    else $error("second drive enable wrong");
  a_first_oe: assert property (shared_first_oe_o == (!cl1 && shared_enable_first_i))
    else $error("first drive enable wrong");
  a_export_match: assert property (shared_second_oe_o |-> shared_second_o == time_base_two_o)
    else $error("exported word differs");
  a_export_first: assert property (shared_first_oe_o |-> shared_first_o == time_base_one_o)
    else $error("exported first word differs");
  a_import_two: assert property (mc_phase_o == 2'h1 && cl2 |=>
    time_base_two_o == $past(shared_second_i))
    else $error("second import missed");
  a_import_one: assert property (mc_phase_o == 2'h1 && cl1 |=>
    time_base_one_o == $past(shared_first_i))
    else $error("first import missed");
  a_client_nowrite: assert property (cl2 && eng_wr_second_i && mc_phase_o != 2'h1 |=>
    $stable(time_base_two_o))
    else $error("client base took a write");
  a_angle_gate: assert property (angle_active_o == (angle_mode_bit_i && !cl2))
    else $error("angle active wrong");
  a_chan0_path: assert property (!angle_active_o |-> chan0_level_o == chan0_filtered_i)
    else $error("channel 0 path wrong");
endmodule
bind dual_time_base_counters dual_time_base_counters_chk #(.W(W)) u_chk (.*);

// file: test/peer_time_engine.sv
`timescale 1ns/1ps
// peer engine on the shared bus
module peer_time_engine (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // serving control and bus word
  input wire logic serve_i,
  output logic [23:0] word_o
);
  logic [23:0] cnt_ff;
  // the peer only advances while serving
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 24'h000100;
    end else if (serve_i) begin
      cnt_ff <= cnt_ff + 24'h000003;
    end
  end
  // no pull on the bus, so a released word must not look valid
  assign word_o = serve_i ? cnt_ff : ~cnt_ff;
endmodule

// file: test/dual_time_base_counters_tb.sv
`timescale 1ns/1ps
module dual_time_base_counters_tb;
  import time_base_pkg::*;
  // stimulus
  logic clk = 0, rst_n = 0, tick = 0, ptick = 0, fclk = 0, atick = 0, amode = 0;
  logic en1 = 0, ro1 = 0, en2 = 0, ro2 = 0, wr1 = 0, wr2 = 0;
  first_clock_select_t fsel = FIRST_SYS_DIV2;
  second_clock_select_t ssel = SECOND_OFF;
  logic [7:0] fp = 8'h00;
  logic [5:0] sp = 6'h00;
  logic [1:0] tfc = 2'h0;
  logic [2:0] div = 3'h0;
  logic [23:0] wd = 24'h000000;
  logic [31:0] mof = 32'h0, cen = 32'h0, trn = 32'h0, clr = 32'h0;
  logic [767:0] mv = '0;
  // observed
  logic [23:0] tb1, tb2, word;
  logic [1:0] ph;
  logic oe1, oe2, aact, c0l;
  logic [31:0] ml1, ml2;
  logic [767:0] cp1, cp2;
  int fail_count = 0, checks_done = 0;
  always #25 clk = ~clk;
  // peripheral and channel filter strobes, one cycle wide
  always @(posedge clk) begin
    div <= div + 3'h1;
    ptick <= (div == 3'h7);
    fclk <= (div[1:0] == 2'h3);
  end
  peer_time_engine peer (.core_clk_i(clk), .rst_n_i(rst_n), .serve_i(en2 & ~ro2),
    .word_o(word));
  dual_time_base_counters dut (.core_clk_i(clk), .rst_n_i(rst_n), .tick_i(tick),
    .periph_tick_i(ptick), .chan_filt_clk_i(fclk), .angle_tick_i(atick),
    .first_clock_select_i(fsel), .first_prescale_field_i(fp),
    .second_clock_select_i(ssel), .second_prescale_field_i(sp),
    .tick_filter_control_i(tfc), .angle_mode_bit_i(amode),
    .shared_enable_first_i(en1), .shared_role_first_i(ro1),
    .shared_enable_second_i(en2), .shared_role_second_i(ro2),
    .eng_wr_first_i(wr1), .eng_wr_second_i(wr2), .eng_wdata_i(wd),
    .shared_first_i(word), .shared_second_i(word), .shared_first_o(),
    .shared_first_oe_o(oe1), .shared_second_o(), .shared_second_oe_o(oe2),
    .time_base_one_o(tb1), .time_base_two_o(tb2), .mc_phase_o(ph),
    .angle_active_o(aact), .chan0_filtered_i(div[2]), .chan0_level_o(c0l),
    .match_on_first_i(mof), .match1_val_i(mv), .match2_val_i(mv),
    .match1_clr_i(clr), .match2_clr_i(clr), .transition_i(trn),
    .cap1_en_i(cen), .cap2_en_i(cen), .match1_latch_o(ml1), .match2_latch_o(ml2),
    .capture1_o(cp1), .capture2_o(cp2));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string n, logic [23:0] seen, logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // settle just after a commit so both bases are steady
  task automatic snap(output logic [23:0] a, b);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      #1 i++;
    end while (ph !== 2'h2 && i < 5);
    if (ph !== 2'h2) begin
      fail_count++;
      finish_test();
    end
    a = tb1;
    b = tb2;
  endtask
  // window is a whole number of divider periods, so counts are exact
  task automatic rate(first_clock_select_t f, logic [7:0] p1, second_clock_select_t s,
      logic [5:0] p2, logic t, int n, logic [23:0] e1, e2);
    logic [23:0] a1, a2, b1, b2;
    @(posedge clk);
    fsel <= f;
    fp <= p1;
    ssel <= s;
    sp <= p2;
    tick <= t;
    repeat (16) @(posedge clk);
    snap(a1, a2);
    repeat (n - 1) @(posedge clk);
    snap(b1, b2);
    chk("rate one", b1 - a1, e1);
    chk("rate two", b2 - a2, e2);
  endtask
  task automatic edges();
    logic [23:0] a1, a2, b1, b2;
    for (int c = 0; c < 4; c++) begin
      for (int s = 2; s < 5; s++) begin
        @(posedge clk);
        fsel <= FIRST_EXT;
        fp <= 8'h00;
        sp <= 6'h00;
        ssel <= second_clock_select_t'(s);
        tfc <= c[1:0];
        repeat (16) @(posedge clk);
        snap(a1, a2);
        repeat (6) begin
          repeat (c[0] ? 16 : 5) @(posedge clk);
          tick <= ~tick;
        end
        repeat (30) @(posedge clk);
        snap(b1, b2);
        chk("edge one", b1 - a1, 24'h3);
        chk("edge two", b2 - a2, (s == 4) ? 24'h6 : 24'h3);
      end
    end
  endtask
  task automatic share();
    logic [23:0] a1, a2;
    @(posedge clk);
    en1 <= 1'b1;
    ro1 <= 1'b1;
    en2 <= 1'b1;
    ro2 <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk("drive", 24'({oe1, oe2}), 24'h3);
    @(posedge clk);
    ro1 <= 1'b0;
    ro2 <= 1'b0;
    wd <= 24'h000000;
    repeat (8) @(posedge clk);
    wr1 <= 1'b1;
    wr2 <= 1'b1;
    repeat (4) @(posedge clk);
    wr1 <= 1'b0;
    wr2 <= 1'b0;
    snap(a1, a2);
    chk("import one", a1, word - 24'h3);
    chk("import two", a2, word - 24'h3);
    chk("client", 24'({oe1, oe2}), 24'h0);
    @(posedge clk);
    en1 <= 1'b0;
    en2 <= 1'b0;
  endtask
  task automatic wrap();
    logic [23:0] a1, a2, b1, b2;
    @(posedge clk);
    fsel <= FIRST_SYS_DIV2;
    ssel <= SECOND_INT;
    wr1 <= 1'b1;
    wr2 <= 1'b1;
    wd <= 24'hFFFFFA;
    @(posedge clk);
    wr1 <= 1'b0;
    wr2 <= 1'b0;
    snap(a1, a2);
    repeat (63) @(posedge clk);
    snap(b1, b2);
    chk("wrap one", b1, a1 + 24'h20);
    chk("wrap two", b2, a2 + 24'h8);
  endtask
  task automatic angle();
    logic [23:0] a1, a2, b1, b2;
    @(posedge clk);
    ssel <= SECOND_RISE;
    amode <= 1'b1;
    tick <= 1'b1;
    repeat (12) @(posedge clk);
    #1 chk("chan0 path", 24'(c0l), 24'h1);
    snap(a1, a2);
    repeat (5) begin
      @(posedge clk);
      atick <= 1'b1;
      @(posedge clk);
      atick <= 1'b0;
      tick <= ~tick;
      repeat (8) @(posedge clk);
    end
    repeat (20) @(posedge clk);
    snap(b1, b2);
    chk("angle ticks", b2 - a2, 24'h5);
    @(posedge clk);
    en2 <= 1'b1;
    @(posedge clk);
    #1 chk("client angle", 24'(aact), 24'h0);
    @(posedge clk);
    en2 <= 1'b0;
    amode <= 1'b0;
  endtask
  task automatic match();
    logic [23:0] v;
    int i;
    @(posedge clk);
    #1 v = tb1 + 24'h40;
    @(posedge clk);
    fsel <= FIRST_SYS_DIV2;
    mof <= 32'h00000001;
    cen <= 32'h00000001;
    mv <= {720'h0, v, v};
    for (i = 0; i < 200 && ml1[0] !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 200) begin
      fail_count++;
      finish_test();
    end
    chk("latches", 24'({ml1[1:0], ml2[1:0]}), 24'h5);
    chk("capture", 24'(cp1[23:0] >= v && cp1[23:0] <= tb1 && cp2[23:0] == cp1[23:0]),
      24'h1);
    // clear while still hitting: the hit must win
    @(posedge clk);
    clr <= 32'h00000001;
    @(posedge clk);
    clr <= 32'h00000000;
    mv <= '1;
    #1 chk("set wins", 24'({ml1[0], ml2[0]}), 24'h3);
    // clear with no hit, then an input transition captures the base
    @(posedge clk);
    clr <= 32'h00000001;
    @(posedge clk);
    clr <= 32'h00000000;
    trn <= 32'h00000001;
    #1 v = tb1;
    chk("cleared", 24'({ml1[0], ml2[0]}), 24'h0);
    @(posedge clk);
    trn <= 32'h00000000;
    #1 chk("transition one", cp1[23:0], v);
    chk("transition two", cp2[23:0], v);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rate(FIRST_SYS_DIV2, 8'h00, SECOND_INT, 6'h00, 1'b0, 64, 24'h20, 24'h8);
    rate(FIRST_SYS_DIV2, 8'h03, SECOND_INT, 6'h01, 1'b0, 64, 24'h8, 24'h4);
    rate(FIRST_SYS_DIV2, 8'hFF, SECOND_INT, 6'h3F, 1'b0, 512, 24'h1, 24'h1);
    rate(FIRST_PERIPH, 8'h00, SECOND_GATED, 6'h00, 1'b1, 64, 24'h8, 24'h8);
    rate(FIRST_PERIPH, 8'h07, SECOND_GATED, 6'h3F, 1'b1, 512, 24'h8, 24'h1);
    rate(FIRST_PERIPH, 8'h00, SECOND_GATED, 6'h00, 1'b0, 64, 24'h8, 24'h0);
    edges();
    share();
    wrap();
    angle();
    match();
    finish_test();
  end
endmodule
